// >>> spc_serial_port.sv
// Serial control port of the device: link logic on sclk, registers on mclk.
// Assumes a host that samples on rising sclk, idles sclk low, and pauses
// sclk after the instruction of a read frame as the handover describes.
`timescale 1ns/100ps
`default_nettype none
`include "spc_cfg.svh"

// Behaviour
// - With output select 0, read data leave on the shared data pin and the separate output pin stays undriven.
// - With output select 1, read data leave only on the separate output pin while writes come in on the shared pin.
// - With bit order 0, bits shift most significant first and the address falls by one per byte.
// - With bit order 1, bits shift least significant first and the address rises by one per byte.
// - A 1 in the soft-reset bit holds the bank select, the update bit and both banks at defaults until the host writes it back to 0.
// - Readback gives buffer registers when the bank select is 0 and active registers when it is 1.
// - Writing the update bit copies the buffer registers into the active ones and the bit clears itself.
module spc_serial_port #(
	parameter int BANK_DEPTH = 16,
	parameter int BANK_AW    = 4
) (
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	input  wire logic                      sclk,
	input  wire logic                      csb_n,
	input  wire logic                      sdio_i,
	output var  logic                      sdio_o,
	output var  logic                      sdio_oe,
	output var  logic                      serial_output_pin_o,
	output var  logic                      serial_output_pin_oe,
	output var  logic                      soft_reset,
	output var  logic [BANK_DEPTH*8-1:0]   active_regs
);

	localparam int RD_CYC = `SPC_RD_GAP_CYC;

	// Rising-edge link state
	typedef struct packed {
		logic [1:0]          cfg_s1;
		logic [1:0]          cfg_s2;
		spc_pkg::spc_phase_t ph;
		logic [3:0]          cnt;
		logic [15:0]         raw;
		logic                rd;
		logic [12:0]         addr;
		logic                wr_tgl;
		logic [12:0]         wr_addr;
		logic [7:0]          wr_data;
		logic                rd_tgl;
		logic [12:0]         rd_addr;
	} spc_lk_t;

	// Falling-edge link state: output shifter and pin enables
	typedef struct packed {
		logic [7:0] sh;
		logic       obit;
		logic       oe_io;
		logic       oe_out;
	} spc_ln_t;

	typedef struct packed {
		logic [2:0] wr_s;
		logic [2:0] rd_s;
		logic [7:0] setup;
		logic       rbsel;
		logic       upd;
		logic [7:0] rd_word;
		logic       rd_pend;
	} spc_mc_t;

	spc_lk_t q_lk;
	spc_lk_t d_lk;
	spc_ln_t q_ln;
	spc_ln_t d_ln;
	spc_mc_t q_mc;
	spc_mc_t d_mc;
	logic    fr_rst_n;
	logic    alive_q;
	logic    opsel;
	logic    lsbf;
	logic    wr_ev;
	logic    rd_ev;
	logic    srst;
	logic    mem_wr;
	logic    mem_rd;
	logic [7:0] mem_rdat;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction

	function automatic spc_pkg::spc_rsel_t reg_sel(input logic [12:0] a);
		spc_pkg::spc_rsel_t s;
		s = spc_pkg::RS_NONE;
		if (a == `SPC_ADDR_SETUP) begin
			s = spc_pkg::RS_SETUP;
		end else if (a == `SPC_ADDR_RBSEL) begin
			s = spc_pkg::RS_RBSEL;
		end else if (a == `SPC_ADDR_UPDATE) begin
			s = spc_pkg::RS_UPD;
		end else if (a >= `SPC_BANK_BASE &&
				{1'b0, a} < {1'b0, `SPC_BANK_BASE} + 14'(BANK_DEPTH)) begin
			s = spc_pkg::RS_BANK;
		end
		return s;
	endfunction

	function automatic logic [BANK_AW-1:0] bank_idx(input logic [12:0] a);
		logic [12:0] o;
		o = a - `SPC_BANK_BASE;
		return o[BANK_AW-1:0];
	endfunction

	function automatic logic [12:0] step(input logic [12:0] a,
			input logic lsb);
		return lsb ? a + 13'h1 : a - 13'h1;
	endfunction

	// ---------------- Link side, rising sclk ----------------
	assign fr_rst_n = resetn & ~csb_n;
	assign opsel    = q_lk.cfg_s2[1];
	assign lsbf     = q_lk.cfg_s2[0];

	// Marks that the current frame has seen a rising edge; a frame's own
	// chip select clears it, since sclk stands still between frames.
	always_ff @(posedge sclk or negedge fr_rst_n) begin
		if (!fr_rst_n) begin
			alive_q <= 1'b0;
		end else begin
			alive_q <= 1'b1;
		end
	end

	always_comb begin
		logic [3:0]  cnt;
		logic [15:0] iw;
		cnt = alive_q ? q_lk.cnt : 4'h0;
		iw = 16'h0000;
		d_lk = q_lk;
		// bits 7 and 6 read alike in either order since write data are stored in natural bit order
		d_lk.cfg_s1 = {q_mc.setup[`SPC_BIT_OPSEL], q_mc.setup[`SPC_BIT_LSBF]};
		d_lk.cfg_s2 = q_lk.cfg_s1;
		d_lk.raw = {q_lk.raw[14:0], sdio_i};
		case (alive_q ? q_lk.ph : spc_pkg::PH_INSTR)
			spc_pkg::PH_INSTR: begin
				d_lk.ph = spc_pkg::PH_INSTR;
				d_lk.cnt = cnt + 4'h1;
				if (cnt == `SPC_INSTR_LAST) begin
					// Raw bits are kept in arrival order and reordered at the end
					iw = lsbf ? {rev8(d_lk.raw[7:0]), rev8(d_lk.raw[15:8])}
						: d_lk.raw;
					d_lk.ph = spc_pkg::PH_DATA;
					d_lk.cnt = 4'h0;
					d_lk.rd = iw[`SPC_BIT_RW];
					d_lk.addr = iw[12:0];
					if (iw[`SPC_BIT_RW]) begin
						d_lk.rd_tgl = ~q_lk.rd_tgl;
						d_lk.rd_addr = iw[12:0];
					end
				end
			end
			spc_pkg::PH_DATA: begin
				d_lk.cnt = {1'b0, cnt[2:0] + 3'h1};
				// Prefetch the next byte while the current one shifts out
				if (q_lk.rd && cnt[2:0] == 3'h0) begin
					d_lk.rd_tgl = ~q_lk.rd_tgl;
					d_lk.rd_addr = step(q_lk.addr, lsbf);
				end
				if (cnt[2:0] == `SPC_BYTE_LAST) begin
					if (!q_lk.rd) begin
						d_lk.wr_tgl = ~q_lk.wr_tgl;
						d_lk.wr_addr = q_lk.addr;
						d_lk.wr_data = lsbf ? rev8(d_lk.raw[7:0])
							: d_lk.raw[7:0];
					end
					d_lk.addr = step(q_lk.addr, lsbf);
				end
			end
			default: begin
				d_lk.ph = spc_pkg::PH_INSTR;
				d_lk.cnt = 4'h0;
			end
		endcase
	end

	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn) begin
			q_lk <= '{cfg_s1: 2'h0, cfg_s2: 2'h0, ph: spc_pkg::PH_INSTR,
				cnt: 4'h0, raw: 16'h0000, rd: 1'b0, addr: 13'h0000,
				wr_tgl: 1'b0, wr_addr: 13'h0000, wr_data: 8'h00,
				rd_tgl: 1'b0, rd_addr: 13'h0000};
		end else begin
			q_lk <= d_lk;
		end
	end

	// ---------------- Link side, falling sclk ----------------
	always_comb begin
		logic [7:0] byte_v;
		byte_v = q_ln.sh;
		d_ln = q_ln;
		d_ln.oe_io = 1'b0;
		d_ln.oe_out = 1'b0;
		if (alive_q && q_lk.ph == spc_pkg::PH_DATA && q_lk.rd) begin
			// Word held still by mclk since its answer; the host pause before the
			// first byte and the prefetch a byte ahead keep this capture clear of its change.
			if (q_lk.cnt[2:0] == 3'h0) begin
				byte_v = q_mc.rd_word;
			end
			d_ln.sh = byte_v;
			d_ln.obit = lsbf ? byte_v[q_lk.cnt[2:0]]
				: byte_v[3'h7 - q_lk.cnt[2:0]];
			d_ln.oe_io = ~opsel;
			d_ln.oe_out = opsel;
		end
	end

	always_ff @(negedge sclk or negedge fr_rst_n) begin
		if (!fr_rst_n) begin
			q_ln <= '{sh: 8'h00, obit: 1'b0, oe_io: 1'b0, oe_out: 1'b0};
		end else begin
			q_ln <= d_ln;
		end
	end

	assign sdio_o               = q_ln.obit;
	assign sdio_oe              = q_ln.oe_io;
	assign serial_output_pin_o  = q_ln.obit;
	assign serial_output_pin_oe = q_ln.oe_out;

	// ---------------- Register side, mclk ----------------
	assign wr_ev = q_mc.wr_s[1] ^ q_mc.wr_s[2];
	assign rd_ev = q_mc.rd_s[1] ^ q_mc.rd_s[2];
	assign srst  = q_mc.setup[`SPC_BIT_SRST];

	always_comb begin
		d_mc = q_mc;
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		d_mc.wr_s = {q_mc.wr_s[1:0], q_lk.wr_tgl};
		d_mc.rd_s = {q_mc.rd_s[1:0], q_lk.rd_tgl};
		d_mc.upd = 1'b0;
		d_mc.rd_pend = 1'b0;
		if (wr_ev) begin
			case (reg_sel(q_lk.wr_addr))
				spc_pkg::RS_SETUP: d_mc.setup = q_lk.wr_data;
				spc_pkg::RS_RBSEL: d_mc.rbsel = q_lk.wr_data[`SPC_BIT_RBSEL];
				spc_pkg::RS_UPD:   d_mc.upd = q_lk.wr_data[`SPC_BIT_UPDATE];
				spc_pkg::RS_BANK:  mem_wr = 1'b1;
				default:           d_mc.setup = q_mc.setup;
			endcase
		end
		if (srst) begin
			// Setup itself stays writable so the host can end the reset
			d_mc.rbsel = 1'b0;
			d_mc.upd = 1'b0;
			mem_wr = 1'b0;
		end
		if (rd_ev) begin
			case (reg_sel(q_lk.rd_addr))
				spc_pkg::RS_SETUP: d_mc.rd_word = q_mc.setup;
				spc_pkg::RS_RBSEL: d_mc.rd_word = {7'h00, q_mc.rbsel};
				spc_pkg::RS_UPD:   d_mc.rd_word = {7'h00, q_mc.upd};
				spc_pkg::RS_BANK: begin
					mem_rd = 1'b1;
					d_mc.rd_pend = 1'b1;
				end
				default:           d_mc.rd_word = 8'h00;
			endcase
		end
		if (q_mc.rd_pend) begin
			d_mc.rd_word = mem_rdat;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			q_mc <= '{wr_s: 3'h0, rd_s: 3'h0, setup: `SPC_SETUP_RST,
				rbsel: 1'b0, upd: 1'b0, rd_word: 8'h00, rd_pend: 1'b0};
		end else begin
			q_mc <= d_mc;
		end
	end

	spc_bank_mem #(
		.DEPTH (BANK_DEPTH),
		.AW    (BANK_AW)
	) u_mem (
		.mclk        (mclk),
		.resetn      (resetn),
		.clear       (srst),
		.wr_en       (mem_wr),
		.wr_addr     (bank_idx(q_lk.wr_addr)),
		.wr_data     (q_lk.wr_data),
		.update      (q_mc.upd),
		.rd_en       (mem_rd),
		.rd_addr     (bank_idx(q_lk.rd_addr)),
		.rd_active   (q_mc.rbsel),
		.rd_data     (mem_rdat),
		.active_flat (active_regs)
	);

	assign soft_reset = srst;

	// ---------------- Checks ----------------
	srst_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		srst |=> !q_mc.rbsel && !q_mc.upd)
		else $error("register not held at default during soft reset");
	upd_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
		q_mc.upd |=> !q_mc.upd)
		else $error("update bit did not clear itself");
	rd_answer_a: assert property (@(posedge mclk) disable iff (!resetn)
		rd_ev |=> ##[0:RD_CYC] !q_mc.rd_pend)
		else $error("read answer not ready in time");
	sdio_mode_a: assert property (@(negedge sclk) disable iff (!fr_rst_n)
		alive_q && q_lk.ph == spc_pkg::PH_DATA && q_lk.rd && !opsel
		|=> sdio_oe && !serial_output_pin_oe)
		else $error("shared pin mode drove the wrong pin");
	sdo_mode_a: assert property (@(negedge sclk) disable iff (!fr_rst_n)
		alive_q && q_lk.ph == spc_pkg::PH_DATA && q_lk.rd && opsel
		|=> serial_output_pin_oe && !sdio_oe)
		else $error("output pin mode drove the wrong pin");
	addr_down_a: assert property (@(posedge sclk) disable iff (!fr_rst_n)
		alive_q && q_lk.ph == spc_pkg::PH_DATA && !lsbf &&
		q_lk.cnt[2:0] == 3'h7 |=> q_lk.addr == $past(q_lk.addr) - 13'h1)
		else $error("address did not fall after a byte");
	addr_up_a: assert property (@(posedge sclk) disable iff (!fr_rst_n)
		alive_q && q_lk.ph == spc_pkg::PH_DATA && lsbf &&
		q_lk.cnt[2:0] == 3'h7 |=> q_lk.addr == $past(q_lk.addr) + 13'h1)
		else $error("address did not rise after a byte");

	wr_seen_c: cover property (@(posedge mclk) disable iff (!resetn)
		wr_ev && reg_sel(q_lk.wr_addr) == spc_pkg::RS_BANK);
	rd_seen_c: cover property (@(posedge mclk) disable iff (!resetn)
		rd_ev ##1 q_mc.rd_pend);
	upd_seen_c: cover property (@(posedge mclk) disable iff (!resetn)
		q_mc.upd);
	srst_seen_c: cover property (@(posedge mclk) disable iff (!resetn)
		$fell(srst));

endmodule // spc_serial_port

`default_nettype wire

// >>> spc_cfg.svh
// Register map, field positions, reset values and timing counts of the
// serial control port. Assumes a 125 MHz mclk.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

`define SPC_ADDR_W       13
`define SPC_ADDR_SETUP   13'h000
`define SPC_ADDR_RBSEL   13'h004
`define SPC_ADDR_UPDATE  13'h232
`define SPC_BANK_BASE    13'h010

`define SPC_SETUP_RST    8'h18
`define SPC_BANK_RST     8'h00
`define SPC_BIT_OPSEL    7
`define SPC_BIT_LSBF     6
`define SPC_BIT_SRST     5
`define SPC_BIT_LONG     4
`define SPC_BIT_RBSEL    0
`define SPC_BIT_UPDATE   0
`define SPC_BIT_RW       15

`define SPC_INSTR_LAST   4'hf
`define SPC_BYTE_LAST    3'h7

`define SPC_MCLK_NS      8
`define SPC_RD_GAP_NS    80
`define SPC_RD_GAP_CYC   ((`SPC_RD_GAP_NS + `SPC_MCLK_NS - 1) / `SPC_MCLK_NS)

`endif

// >>> spc_pkg.sv
// Types shared by the serial control port modules.
// Assumes nothing of its surroundings.
package spc_pkg;

	typedef enum logic [1:0] {
		PH_INSTR = 2'b01,
		PH_DATA  = 2'b10
	} spc_phase_t;

	typedef enum logic [3:0] {
		RS_NONE  = 4'h0,
		RS_SETUP = 4'h1,
		RS_RBSEL = 4'h2,
		RS_UPD   = 4'h4,
		RS_BANK  = 4'h8
	} spc_rsel_t;

endpackage

// >>> spc_bank_mem.sv
// Buffer and active register banks with a registered read port.
// Assumes single-cycle strobes from logic on mclk.
`timescale 1ns/100ps
`default_nettype none
`include "spc_cfg.svh"

module spc_bank_mem #(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	input  wire logic                 clear,
	input  wire logic                 wr_en,
	input  wire logic [AW-1:0]        wr_addr,
	input  wire logic [7:0]           wr_data,
	input  wire logic                 update,
	input  wire logic                 rd_en,
	input  wire logic [AW-1:0]        rd_addr,
	input  wire logic                 rd_active,
	output var  logic [7:0]           rd_data,
	output var  logic [DEPTH*8-1:0]   active_flat
);

	typedef struct packed {
		logic [DEPTH-1:0][7:0] bufr;
		logic [DEPTH-1:0][7:0] act;
		logic [7:0]            rdat;
	} spc_mem_st_t;

	spc_mem_st_t q;
	spc_mem_st_t d;
	logic [7:0]  buf_word;
	logic [7:0]  act_word;

	always_comb begin
		d = q;
		if (clear) begin
			d.bufr = {DEPTH{`SPC_BANK_RST}};
			d.act  = {DEPTH{`SPC_BANK_RST}};
		end else begin
			if (wr_en) begin
				d.bufr[wr_addr] = wr_data;
			end
			// A write in the update cycle lands in the buffer only
			if (update) begin
				d.act = q.bufr;
			end
		end
		if (rd_en) begin
			d.rdat = rd_active ? q.act[rd_addr] : q.bufr[rd_addr];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			q <= '{bufr: {DEPTH{`SPC_BANK_RST}}, act: {DEPTH{`SPC_BANK_RST}},
				rdat: 8'h00};
		end else begin
			q <= d;
		end
	end

	assign rd_data     = q.rdat;
	assign active_flat = q.act;
	assign buf_word    = q.bufr[rd_addr];
	assign act_word    = q.act[rd_addr];

	upd_copy_a: assert property (@(posedge mclk) disable iff (!resetn)
		update && !clear |=> q.act == $past(q.bufr))
		else $error("active bank not loaded from buffer on update");
	rd_buffer_a: assert property (@(posedge mclk) disable iff (!resetn)
		rd_en && !rd_active |=> rd_data == $past(buf_word))
		else $error("buffer readback returned wrong word");
	rd_active_a: assert property (@(posedge mclk) disable iff (!resetn)
		rd_en && rd_active |=> rd_data == $past(act_word))
		else $error("active readback returned wrong word");

endmodule // spc_bank_mem

`default_nettype wire

// >>> spc_host_model.sv
// Host controller model driving the serial control port link.
// Assumes the testbench passes the bit order and pin mode now in force.
`timescale 1ns/100ps
`default_nettype none

module spc_host_model (
	output var  logic       sclk,
	output var  logic       csb_n,
	output wire logic       sdio_i,
	input  wire logic       sdio_o,
	input  wire logic       sdio_oe,
	input  wire logic       serial_output_pin_o,
	input  wire logic       serial_output_pin_oe,
	output var  logic       rd_stb,
	output var  logic [9:0] rd_res
);
	localparam realtime HALF = 7.5;
	logic drv;

	// Released host toggles its level so a stale bit never looks valid
	assign sdio_i = sdio_oe ? sdio_o : drv;

	initial begin
		sclk = 1'b0;
		csb_n = 1'b1;
		drv = 1'b0;
		rd_stb = 1'b0;
		rd_res = 10'h000;
	end

	task automatic tick(input logic b);
		sclk = 1'b0;
		drv = b;
		#HALF sclk = 1'b1;
		#HALF;
	endtask

	// Sclk stands low between frames
	task automatic xfer(input logic rd, input logic [12:0] a, input int n,
		input logic [31:0] wd, input logic lsb, input logic sep);
		logic [15:0] w;
		logic [7:0]  b;
		logic [1:0]  oe;
		int          i;
		int          k;
		w = {rd, 2'b00, a};
		csb_n = 1'b0;
		for (i = 0; i < 16; i++) tick(lsb ? w[i] : w[15-i]);
		// Read turnaround pause with sclk high
		if (rd) #90;
		for (k = 0; k < n; k++) begin
			for (i = 0; i < 8; i++) begin
				if (rd) begin
					sclk = 1'b0;
					drv = ~drv;
					#HALF sclk = 1'b1;
					b[lsb ? i : 7-i] = sep ? serial_output_pin_o : sdio_o;
					if (i == 0) oe = {sdio_oe, serial_output_pin_oe};
					#HALF;
				end else begin
					tick(lsb ? wd[8*k+i] : wd[8*k+7-i]);
				end
			end
			if (rd) begin
				rd_res = {oe, b};
				rd_stb = 1'b1;
				#1 rd_stb = 1'b0;
			end
		end
		csb_n = 1'b1;
		#1 sclk = 1'b0;
		#30;
	endtask
endmodule // spc_host_model
`default_nettype wire

// >>> serial_port_config_tb_top.sv
// Self-checking bench for the serial control port.
// Assumes the host model and the design files are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "spc_cfg.svh"

module serial_port_config_tb_top;
	logic         mclk;
	logic         resetn;
	wire logic    sclk;
	wire logic    csb_n;
	wire logic    sdio_i;
	wire logic    sdio_o;
	wire logic    sdio_oe;
	wire logic    so_o;
	wire logic    so_oe;
	wire logic    soft_reset;
	wire logic    rd_stb;
	wire logic [9:0]   rd_res;
	wire logic [127:0] active_regs;
	logic [7:0]   bufm [16];
	logic [7:0]   actm [16];
	logic [7:0]   setup;
	logic         rbsel;
	logic [31:0]  seed;
	logic [9:0]   exp_q [$];
	int           n_errors;
	int           num_checks;

	spc_serial_port u_dut (.mclk(mclk), .resetn(resetn), .sclk(sclk),
		.csb_n(csb_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
		.serial_output_pin_o(so_o), .serial_output_pin_oe(so_oe),
		.soft_reset(soft_reset), .active_regs(active_regs));

	spc_host_model u_host (.sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_i),
		.sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_output_pin_o(so_o),
		.serial_output_pin_oe(so_oe), .rd_stb(rd_stb), .rd_res(rd_res));

	always #4 mclk = ~mclk;

	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	function automatic logic bank(input logic [12:0] x);
		return x >= `SPC_BANK_BASE && x < `SPC_BANK_BASE + 13'h010;
	endfunction

	function automatic logic [7:0] ev(input logic [12:0] x);
		if (x == `SPC_ADDR_SETUP) return setup;
		if (x == `SPC_ADDR_RBSEL) return {7'h00, rbsel};
		if (bank(x)) return rbsel ? actm[x[3:0]] : bufm[x[3:0]];
		return 8'h00;
	endfunction

	function automatic logic [127:0] actf();
		logic [127:0] r;
		for (int i = 0; i < 16; i++) r[8*i+:8] = actm[i];
		return r;
	endfunction

	task automatic cmp_rd(input logic [9:0] e, input logic [9:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH read_byte expected %h seen %h", e, g);
		end
	endtask

	task automatic cmp_lvl(input string nm, input logic [127:0] e,
		input logic [127:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [12:0] a, input int n, input logic [31:0] d);
		logic [12:0] x;
		logic        lsb;
		lsb = setup[6];
		u_host.xfer(1'b0, a, n, d, setup[6], setup[7]);
		for (int k = 0; k < n; k++) begin
			x = lsb ? a + 13'(k) : a - 13'(k);
			if (x == `SPC_ADDR_SETUP) setup = d[8*k+:8];
			else if (!setup[5]) begin
				if (x == `SPC_ADDR_RBSEL) rbsel = d[8*k];
				if (bank(x)) bufm[x[3:0]] = d[8*k+:8];
				if (x == `SPC_ADDR_UPDATE && d[8*k])
					for (int i = 0; i < 16; i++) actm[i] = bufm[i];
			end
		end
		// Defaults are held for as long as soft reset stays set
		if (setup[5]) begin
			rbsel = 1'b0;
			for (int i = 0; i < 16; i++) bufm[i] = 8'h00;
			for (int i = 0; i < 16; i++) actm[i] = 8'h00;
		end
		repeat (5) @(posedge mclk);
	endtask

	task automatic rd(input logic [12:0] a, input int n);
		logic [12:0] x;
		for (int k = 0; k < n; k++) begin
			x = setup[6] ? a + 13'(k) : a - 13'(k);
			exp_q.push_back({~setup[7], setup[7], ev(x)});
		end
		u_host.xfer(1'b1, a, n, 32'h0, setup[6], setup[7]);
	endtask

	task automatic close_out();
		if (exp_q.size() != 0) n_errors++;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	always @(posedge rd_stb) begin
		if (exp_q.size() == 0) begin
			n_errors++;
			$display("MISMATCH read_byte expected none seen %h", rd_res);
		end else begin
			cmp_rd(exp_q.pop_front(), rd_res);
		end
	end

	initial begin
		#200000;
		n_errors++;
		close_out();
	end

	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		seed = 32'd82;
		setup = `SPC_SETUP_RST;
		rbsel = 1'b0;
		n_errors = 0;
		num_checks = 0;
		for (int i = 0; i < 16; i++) bufm[i] = 8'h00;
		for (int i = 0; i < 16; i++) actm[i] = 8'h00;
		repeat (12) @(posedge mclk);
		#1 resetn = 1'b1;
		repeat (4) @(posedge mclk);
		rd(`SPC_ADDR_SETUP, 1);
		rd(`SPC_ADDR_RBSEL, 1);
		rd(13'h100, 1);
		wr(13'h013, 3, {8'h00, xs(), xs(), xs()});
		rd(13'h013, 3);
		wr(`SPC_ADDR_SETUP, 1, 32'h5a);
		rd(`SPC_ADDR_SETUP, 1);
		wr(13'h014, 2, {16'h0000, xs(), xs()});
		rd(13'h013, 3);
		wr(`SPC_ADDR_SETUP, 1, 32'hdb);
		rd(13'h013, 3);
		wr(`SPC_ADDR_SETUP, 1, {24'h0, `SPC_SETUP_RST});
		wr(`SPC_ADDR_RBSEL, 1, 32'h01);
		rd(13'h013, 3);
		wr(`SPC_ADDR_UPDATE, 1, 32'h01);
		cmp_lvl("active_regs", actf(), active_regs);
		rd(`SPC_ADDR_UPDATE, 1);
		rd(13'h013, 3);
		wr(`SPC_ADDR_SETUP, 1, 32'h3c);
		cmp_lvl("soft_reset", 128'h1, 128'(soft_reset));
		cmp_lvl("active_regs", actf(), active_regs);
		wr(13'h013, 1, 32'h77);
		wr(`SPC_ADDR_SETUP, 1, {24'h0, `SPC_SETUP_RST});
		cmp_lvl("soft_reset", 128'h0, 128'(soft_reset));
		rd(`SPC_ADDR_RBSEL, 1);
		rd(13'h013, 1);
		close_out();
	end
endmodule // serial_port_config_tb_top
`default_nettype wire
